// [logic/i2cas_pkg.sv]
/*
 * Constants and types shared by the I2C target address select block.
 * Assumes an 8-bit conversion result of the strap divider, full scale = ratio 1.0.
 */
package i2cas_pkg;

    localparam int          NUM_PORTS      = 2;
    localparam int          STRAP_W        = 8;
    localparam int          CODE_W         = 3;

    // fixed upper nibble of the primary port address, bits 7..4 of the byte
    localparam logic [3:0]  PRI_ADDR_HI    = 4'h4;
    // 7-bit address of the secondary port, byte bits 7..1 = 0111000
    localparam logic [6:0]  SEC_ADDR       = 7'h38;

    // strap thresholds, ratio x 256, placed in the gaps between the decode bands
    localparam logic [7:0]  STRAP_TH_1     = 8'h31;  // 0.19
    localparam logic [7:0]  STRAP_TH_2     = 8'h64;  // 0.39
    localparam logic [7:0]  STRAP_TH_3     = 8'h97;  // 0.59
    localparam logic [2:0]  CODE_BAND_0    = 3'h0;
    localparam logic [2:0]  CODE_BAND_1    = 3'h1;
    localparam logic [2:0]  CODE_BAND_2    = 3'h2;
    localparam logic [2:0]  CODE_BAND_3    = 3'h3;

    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0]  LAST_TX_BIT    = 4'h7;
    localparam logic [7:0]  BYTE_RST       = 8'h00;
    localparam logic [1:0]  PIN_IDLE       = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_SUB,
        ST_SUB_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK
    } i2cas_state_t;

    function automatic logic [2:0] strap_decode(input logic [7:0] lvl);
        logic [2:0] c;
        c = CODE_BAND_3;
        if (lvl < STRAP_TH_1) begin
            c = CODE_BAND_0;
        end else if (lvl < STRAP_TH_2) begin
            c = CODE_BAND_1;
        end else if (lvl < STRAP_TH_3) begin
            c = CODE_BAND_2;
        end
        return c;
    endfunction

endpackage

// [logic/i2cas_sync.sv]
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes inputs are quasi-static relative to i_clk; no glitch filtering here.
 */
`timescale 1ns/1ps
module i2cas_sync #(
    parameter int              W   = 2,
    parameter logic [W-1:0]    RST = '1
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic [W-1:0]  i_d,
    output logic      [W-1:0]  o_q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= RST;
            o_q    <= RST;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule // i2cas_sync

// [logic/i2cas_top.sv]
/*
 * Two I2C target ports: strap-derived primary address, fixed secondary address,
 * per-port bit mask override, sub-address / data framing with clock stretching.
 * Assumes the strap conversion, firmware mask values and the command back end
 * live outside and share i_clk; bus pins are open drain with external pull-ups.
 */
// What this block does
// - no port answers the bus until boot has set its address
// - primary port address uses a three-bit code decoded from the strap level
// - primary address byte is 0100, strap code in bits 3..1, direction bit 0
// - strap ratio bands map to codes 000, 001, 010, 011
// - secondary port answers fixed address 0111000 with direction in bit 0
// - each address bit maskable per port, independent override of the other port
// - sub-address byte selects a command; following bytes written or read
// - address, sub-address and data phases keep SMBus-style framing
// - matching address is acknowledged by holding data low through ack clock
// - clock held low after each byte until back end ready
`timescale 1ns/1ps
module i2cas_top #(
    parameter int NP = i2cas_pkg::NUM_PORTS
) (
    input  wire logic                                  i_clk,
    input  wire logic                                  i_rst,
    input  wire logic [i2cas_pkg::STRAP_W-1:0]         i_strap_level,
    input  wire logic                                  i_strap_valid,
    input  wire logic                                  i_boot_done,
    input  wire logic [7*NP-1:0]                       i_addr_mask,
    input  wire logic [7*NP-1:0]                       i_addr_ovr,
    input  wire logic [NP-1:0]                         i_scl,
    input  wire logic [NP-1:0]                         i_sda,
    output wire logic [NP-1:0]                         o_scl,
    output wire logic [NP-1:0]                         o_scl_oe_n,
    output wire logic [NP-1:0]                         o_sda,
    output wire logic [NP-1:0]                         o_sda_oe_n,
    input  wire logic [NP-1:0]                         i_ready,
    input  wire logic [8*NP-1:0]                       i_rd_data,
    output wire logic [8*NP-1:0]                       o_sub,
    output wire logic [NP-1:0]                         o_sub_stb,
    output wire logic [8*NP-1:0]                       o_wr_data,
    output wire logic [NP-1:0]                         o_wr_stb,
    output wire logic [NP-1:0]                         o_rd_stb,
    output wire logic [NP-1:0]                         o_port_en,
    output logic      [i2cas_pkg::CODE_W-1:0]          o_strap_code
);

    ////////////////////////////////////////////////////////////////////////////
    // boot: strap capture

    logic strap_done_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            strap_done_r <= 1'b0;
            o_strap_code <= i2cas_pkg::CODE_BAND_0;
        end else if (i_strap_valid && !strap_done_r) begin
            strap_done_r <= 1'b1;
            o_strap_code <= i2cas_pkg::strap_decode(i_strap_level);
        end
    end

    a_strap_decode : assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(strap_done_r) |-> o_strap_code == i2cas_pkg::strap_decode($past(i_strap_level)))
        else $error("strap code does not match captured level");

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, scl and sda of every port

    logic [2*NP-1:0] pins_q;

    i2cas_sync #(.W(2*NP), .RST('1)) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_scl, i_sda}),
        .o_q   (pins_q)
    );

    // open drain: only ever pull low
    assign o_scl = '0;
    assign o_sda = '0;

    ////////////////////////////////////////////////////////////////////////////
    // per-port target engine

    for (genvar p = 0; p < NP; p++) begin : g_port
        logic [6:0]              base_addr;
        logic [6:0]              my_addr;
        logic [6:0]              mask;
        logic                    en;
        logic                    scl_q;
        logic                    sda_q;
        logic [1:0]              prev_r;
        logic                    scl_rise;
        logic                    scl_fall;
        logic                    start_c;
        logic                    stop_c;
        logic                    byte_end;
        i2cas_pkg::i2cas_state_t st_r;
        logic [7:0]              sh_r;
        logic [3:0]              cnt_r;
        logic                    rw_r;
        logic                    mack_r;
        logic                    hold_r;
        logic                    sda_oe_n_r;
        logic [7:0]              sub_r;
        logic [7:0]              wdat_r;
        logic                    sub_stb_r;
        logic                    wr_stb_r;
        logic                    rd_stb_r;

        if (p == 0) begin : g_pri
            assign base_addr = {i2cas_pkg::PRI_ADDR_HI, o_strap_code};
            assign en        = strap_done_r && i_boot_done;
        end else begin : g_sec
            assign base_addr = i2cas_pkg::SEC_ADDR;
            assign en        = i_boot_done;
        end

        assign mask     = i_addr_mask[7*p +: 7];
        assign my_addr  = (base_addr & ~mask) | (i_addr_ovr[7*p +: 7] & mask);
        assign scl_q    = pins_q[NP + p];
        assign sda_q    = pins_q[p];
        assign scl_rise = scl_q && !prev_r[1];
        assign scl_fall = !scl_q && prev_r[1];
        assign start_c  = scl_q && prev_r[1] && !sda_q && prev_r[0];
        assign stop_c   = scl_q && prev_r[1] && sda_q && !prev_r[0];
        assign byte_end = scl_fall && (cnt_r == i2cas_pkg::BITS_PER_BYTE);

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                prev_r <= i2cas_pkg::PIN_IDLE;
            end else begin
                prev_r <= {scl_q, sda_q};
            end
        end

        // framing state machine; shifter, bit count and line drive move with it
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                st_r       <= i2cas_pkg::ST_IDLE;
                sh_r       <= i2cas_pkg::BYTE_RST;
                cnt_r      <= '0;
                rw_r       <= 1'b0;
                mack_r     <= 1'b0;
                hold_r     <= 1'b0;
                sda_oe_n_r <= 1'b1;
                sub_r      <= i2cas_pkg::BYTE_RST;
                wdat_r     <= i2cas_pkg::BYTE_RST;
                sub_stb_r  <= 1'b0;
                wr_stb_r   <= 1'b0;
                rd_stb_r   <= 1'b0;
            end else begin
                sub_stb_r <= 1'b0;
                wr_stb_r  <= 1'b0;
                rd_stb_r  <= 1'b0;
                if (!en || stop_c) begin
                    st_r       <= i2cas_pkg::ST_IDLE;
                    hold_r     <= 1'b0;
                    sda_oe_n_r <= 1'b1;
                end else if (start_c) begin  // repeated start allowed anywhere
                    st_r       <= i2cas_pkg::ST_ADDR;
                    cnt_r      <= '0;
                    hold_r     <= 1'b0;
                    sda_oe_n_r <= 1'b1;
                end else if (hold_r) begin
                    if (i_ready[p]) begin
                        hold_r     <= 1'b0;
                        sda_oe_n_r <= 1'b1;
                        cnt_r      <= '0;
                        case (st_r)
                            i2cas_pkg::ST_ADDR_ACK: begin
                                st_r <= rw_r ? i2cas_pkg::ST_RD : i2cas_pkg::ST_SUB;
                                if (rw_r) begin
                                    sh_r       <= i_rd_data[8*p +: 8];
                                    sda_oe_n_r <= i_rd_data[8*p+7];
                                    rd_stb_r   <= 1'b1;
                                end
                            end
                            i2cas_pkg::ST_SUB_ACK,
                            i2cas_pkg::ST_WR_ACK: begin
                                st_r <= i2cas_pkg::ST_WR;
                            end
                            i2cas_pkg::ST_RD_ACK: begin
                                // controller nack ends the read, line stays free
                                st_r <= mack_r ? i2cas_pkg::ST_RD : i2cas_pkg::ST_IDLE;
                                if (mack_r) begin
                                    sh_r       <= i_rd_data[8*p +: 8];
                                    sda_oe_n_r <= i_rd_data[8*p+7];
                                    rd_stb_r   <= 1'b1;
                                end
                            end
                            default: begin
                                st_r <= i2cas_pkg::ST_IDLE;
                            end
                        endcase
                    end
                end else begin
                    case (st_r)
                        i2cas_pkg::ST_ADDR,
                        i2cas_pkg::ST_SUB,
                        i2cas_pkg::ST_WR: begin
                            if (scl_rise) begin
                                sh_r  <= {sh_r[6:0], sda_q};
                                cnt_r <= cnt_r + 4'h1;
                            end else if (byte_end) begin
                                if (st_r == i2cas_pkg::ST_ADDR) begin
                                    if (sh_r[7:1] == my_addr) begin
                                        st_r       <= i2cas_pkg::ST_ADDR_ACK;
                                        sda_oe_n_r <= 1'b0;
                                        rw_r       <= sh_r[0];
                                    end else begin
                                        st_r <= i2cas_pkg::ST_IDLE;
                                    end
                                end else if (st_r == i2cas_pkg::ST_SUB) begin
                                    st_r       <= i2cas_pkg::ST_SUB_ACK;
                                    sda_oe_n_r <= 1'b0;
                                    sub_r      <= sh_r;
                                    sub_stb_r  <= 1'b1;
                                end else begin
                                    st_r       <= i2cas_pkg::ST_WR_ACK;
                                    sda_oe_n_r <= 1'b0;
                                    wdat_r     <= sh_r;
                                    wr_stb_r   <= 1'b1;
                                end
                            end
                        end
                        i2cas_pkg::ST_RD: begin
                            if (scl_fall) begin
                                cnt_r <= cnt_r + 4'h1;
                                sh_r  <= {sh_r[6:0], 1'b0};
                                if (cnt_r == i2cas_pkg::LAST_TX_BIT) begin
                                    st_r       <= i2cas_pkg::ST_RD_ACK;
                                    sda_oe_n_r <= 1'b1;
                                end else begin
                                    sda_oe_n_r <= sh_r[6];
                                end
                            end
                        end
                        i2cas_pkg::ST_ADDR_ACK,
                        i2cas_pkg::ST_SUB_ACK,
                        i2cas_pkg::ST_WR_ACK,
                        i2cas_pkg::ST_RD_ACK: begin
                            if (scl_rise) begin
                                mack_r <= !sda_q;
                            end else if (scl_fall) begin
                                hold_r <= 1'b1;
                            end
                        end
                        default: begin
                            sda_oe_n_r <= 1'b1;
                        end
                    endcase
                end
            end
        end

        // hold_r rises on the synchronised fall, so scl is already low
        assign o_scl_oe_n[p]     = !hold_r;
        assign o_sda_oe_n[p]     = sda_oe_n_r;
        assign o_sub[8*p +: 8]   = sub_r;
        assign o_wr_data[8*p +: 8] = wdat_r;
        assign o_sub_stb[p]      = sub_stb_r;
        assign o_wr_stb[p]       = wr_stb_r;
        assign o_rd_stb[p]       = rd_stb_r;
        assign o_port_en[p]      = en;

        sequence s_addr_end;
            st_r == i2cas_pkg::ST_ADDR && byte_end && !hold_r && en && !start_c && !stop_c;
        endsequence

        sequence s_data_end;
            st_r == i2cas_pkg::ST_WR && byte_end && !hold_r && en && !start_c && !stop_c;
        endsequence

        a_quiet_before_boot : assert property (@(posedge i_clk) disable iff (i_rst)
            !en ##1 !en |-> o_sda_oe_n[p] && o_scl_oe_n[p])
            else $error("port drives bus before address set");

        a_fixed_address : assert property (@(posedge i_clk) disable iff (i_rst)
            mask == 7'h00 |-> (p == 0 ? (my_addr[6:3] == 4'h8 >> 1 && my_addr[2:0] == o_strap_code)
                                      : my_addr == 7'h38))
            else $error("unmasked port address wrong");

        a_mask_override : assert property (@(posedge i_clk) disable iff (i_rst)
            ((my_addr ^ i_addr_ovr[7*p +: 7]) & mask) == 7'h00)
            else $error("masked address bit not taken from override");

        a_ack_on_match : assert property (@(posedge i_clk) disable iff (i_rst)
            s_addr_end and (sh_r[7:1] == my_addr) |=> !o_sda_oe_n[p] && st_r == i2cas_pkg::ST_ADDR_ACK)
            else $error("matching address not acknowledged");

        // ack must stand until the stretch after the ack clock ends
        a_ack_held : assert property (@(posedge i_clk) disable iff (i_rst)
            st_r == i2cas_pkg::ST_ADDR_ACK && $past(st_r) == i2cas_pkg::ST_ADDR_ACK |-> !o_sda_oe_n[p])
            else $error("acknowledge released during ack clock");

        a_nack_mismatch : assert property (@(posedge i_clk) disable iff (i_rst)
            s_addr_end and (sh_r[7:1] != my_addr) |=> o_sda_oe_n[p] && st_r == i2cas_pkg::ST_IDLE)
            else $error("foreign address acknowledged");

        a_stretch_hold : assert property (@(posedge i_clk) disable iff (i_rst)
            hold_r && !i_ready[p] && en && !start_c && !stop_c |=> !o_scl_oe_n[p])
            else $error("clock released before back end ready");

        a_write_strobe : assert property (@(posedge i_clk) disable iff (i_rst)
            s_data_end |=> o_wr_stb[p] && o_wr_data[8*p +: 8] == $past(sh_r) ##1 !o_wr_stb[p])
            else $error("write byte not delivered once");

        a_sub_before_data : assert property (@(posedge i_clk) disable iff (i_rst)
            st_r == i2cas_pkg::ST_ADDR_ACK && !rw_r && hold_r && i_ready[p] && en && !start_c && !stop_c
                |=> st_r == i2cas_pkg::ST_SUB)
            else $error("data phase entered without sub-address");
    end

endmodule // i2cas_top

// [test/i2cas_ctl_model.sv]
/*
 * Behavioural I2C controller driving one target port of the address select block.
 * Assumes the bench resolves the open-drain lines with pull-ups; steps on falling clock edges.
 */
`timescale 1ns/1ps
module i2cas_ctl_model #(
    parameter int T = 20
) (
    input  wire logic i_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_low,
    output logic      o_sda_low
);
    int stall_err = 0;

    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // bounded wait, so a stretch that never ends shows up as an error
    task automatic scl_up();
        int k;
        k = 0;
        o_scl_low = 1'b0;
        while (i_scl !== 1'b1 && k < 3000) begin
            tick(1);
            k++;
        end
        if (k >= 3000) stall_err++;
        tick(T);
    endtask

    // data changes only while the clock is low
    task automatic bit_io(input logic b, output logic s);
        o_sda_low = ~b;
        tick(T);
        scl_up();
        s = i_sda;
        o_scl_low = 1'b1;
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic start(input logic rep);
        if (rep) begin
            o_sda_low = 1'b0;
            tick(T);
            scl_up();
        end
        o_sda_low = 1'b1;
        tick(T);
        o_scl_low = 1'b1;
        tick(T);
    endtask

    task automatic stop();
        o_sda_low = 1'b1;
        tick(T);
        scl_up();
        o_sda_low = 1'b0;
        tick(T);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask

    task automatic rd_byte(output logic [7:0] d, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask
endmodule  // i2cas_ctl_model

// [test/tb_top.sv]
/*
 * Self-checking bench for the I2C target address select block.
 * Assumes two controller models on the bus pins and external pull-ups on both lines.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: got %h, expected %h", $time, (a), (b)); end end

module tb_top;
    localparam logic [7:0] LV [9]  = '{8'h00, 8'h30, 8'h31, 8'h63, 8'h64, 8'h96, 8'h97, 8'hff, 8'h70};
    localparam logic [2:0] EXP [9] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h2};
    localparam logic [7:0] PRI_W   = {i2cas_pkg::PRI_ADDR_HI, 3'h2, 1'b0};
    localparam logic [7:0] SEC_W   = {i2cas_pkg::SEC_ADDR, 1'b0};

    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  strap_level = 8'h00;
    logic        strap_valid = 1'b0;
    logic        boot_done = 1'b0;
    logic [13:0] addr_mask = 14'h0000;
    logic [13:0] addr_ovr = 14'h0000;
    logic [1:0]  ready = 2'h3;
    logic [15:0] rd_data = 16'h0000;
    wire  [1:0]  scl_low, sda_low;
    logic [1:0]  bus_scl, bus_sda, o_scl, o_scl_oe_n, o_sda, o_sda_oe_n;
    logic [1:0]  o_sub_stb, o_wr_stb, o_rd_stb, o_port_en;
    logic [15:0] o_sub, o_wr_data;
    logic [2:0]  o_strap_code;
    logic        ack;
    logic [7:0]  d;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          wr_cnt = 0;
    int          sub_cnt = 0;
    int          rd_cnt = 0;

    always #5 i_clk = ~i_clk;
    assign bus_scl = ~scl_low & (o_scl_oe_n | o_scl);
    assign bus_sda = ~sda_low & (o_sda_oe_n | o_sda);

    i2cas_top i2cas_top_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_strap_level(strap_level), .i_strap_valid(strap_valid),
        .i_boot_done(boot_done), .i_addr_mask(addr_mask), .i_addr_ovr(addr_ovr),
        .i_scl(bus_scl), .i_sda(bus_sda), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n), .o_sda(o_sda),
        .o_sda_oe_n(o_sda_oe_n), .i_ready(ready), .i_rd_data(rd_data), .o_sub(o_sub),
        .o_sub_stb(o_sub_stb), .o_wr_data(o_wr_data), .o_wr_stb(o_wr_stb), .o_rd_stb(o_rd_stb),
        .o_port_en(o_port_en), .o_strap_code(o_strap_code));
    i2cas_ctl_model ctl0 (.i_clk(i_clk), .i_scl(bus_scl[0]), .i_sda(bus_sda[0]),
        .o_scl_low(scl_low[0]), .o_sda_low(sda_low[0]));
    i2cas_ctl_model ctl1 (.i_clk(i_clk), .i_scl(bus_scl[1]), .i_sda(bus_sda[1]),
        .o_scl_low(scl_low[1]), .o_sda_low(sda_low[1]));

    always @(posedge i_clk) begin
        wr_cnt  += int'(o_wr_stb[0] === 1'b1);
        sub_cnt += int'(o_sub_stb[0] === 1'b1) + int'(o_sub_stb[1] === 1'b1);
        rd_cnt  += int'(o_rd_stb[1] === 1'b1);
    end
    // back end hands out a fresh byte after each one taken
    always @(negedge i_clk) if (o_rd_stb[1] === 1'b1) rd_data[15:8] <= ~rd_data[15:8];

    ////////////////////////////////////////////////////////////////////////////
    task automatic do_reset();
        strap_valid = 1'b0;
        i_rst = 1'b1;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask

    task automatic m_start(input int p, input logic rep);
        if (p == 0) ctl0.start(rep);
        else ctl1.start(rep);
    endtask

    task automatic m_stop(input int p);
        if (p == 0) ctl0.stop();
        else ctl1.stop();
    endtask

    task automatic m_wr(input int p, input logic [7:0] b, output logic a);
        if (p == 0) ctl0.wr_byte(b, a);
        else ctl1.wr_byte(b, a);
    endtask

    task automatic addr_try(input int p, input logic [7:0] b, input logic exp_ack);
        logic a;
        m_start(p, 1'b0);
        m_wr(p, b, a);
        m_stop(p);
        `CHK(a, exp_ack)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_strap();
        for (int i = 0; i < 9; i++) begin
            do_reset();
            `CHK(o_port_en, 2'h0)
            strap_level = LV[i];
            strap_valid = 1'b1;
            @(negedge i_clk);
            strap_level = 8'h00;
            @(negedge i_clk);
            `CHK(o_strap_code, EXP[i])
        end
        strap_valid = 1'b0;
    endtask

    task automatic t_boot();
        addr_try(0, PRI_W, 1'b1);
        `CHK(o_port_en, 2'h0)
        boot_done = 1'b1;
        @(negedge i_clk);
        `CHK(o_port_en, 2'h3)
    endtask

    task automatic t_write();
        m_start(0, 1'b0);
        m_wr(0, PRI_W, ack);
        `CHK(ack, 1'b0)
        m_wr(0, 8'h5a, ack);
        `CHK(o_sub[7:0], 8'h5a)
        m_wr(0, 8'hc3, ack);
        `CHK(o_wr_data[7:0], 8'hc3)
        m_stop(0);
        `CHK(wr_cnt, 1)
        `CHK(sub_cnt, 1)
        `CHK(o_sub[15:8], 8'h00)
    endtask

    task automatic t_read();
        rd_data[15:8] = 8'ha5;
        m_start(1, 1'b0);
        m_wr(1, SEC_W, ack);
        m_wr(1, 8'h11, ack);
        `CHK(o_sub[15:8], 8'h11)
        m_start(1, 1'b1);
        m_wr(1, SEC_W | 8'h01, ack);
        `CHK(ack, 1'b0)
        ctl1.rd_byte(d, 1'b0);
        `CHK(d, 8'ha5)
        ctl1.rd_byte(d, 1'b1);
        `CHK(d, 8'h5a)
        m_stop(1);
        `CHK(rd_cnt, 2)
        `CHK(sub_cnt, 2)
        `CHK(o_wr_data[15:8], 8'h00)
    endtask

    task automatic t_miss();
        addr_try(1, PRI_W, 1'b1);
        addr_try(0, SEC_W, 1'b1);
        addr_try(0, PRI_W ^ 8'h02, 1'b1);
    endtask

    task automatic t_mask();
        addr_mask = 14'h3f81;
        addr_ovr = 14'h2a81;
        addr_try(1, 8'haa, 1'b0);
        addr_try(1, SEC_W, 1'b1);
        addr_try(0, PRI_W | 8'h02, 1'b0);
        addr_try(0, PRI_W, 1'b1);
        addr_mask = 14'h0000;
    endtask

    task automatic t_stretch();
        int k;
        ready = 2'h0;
        fork
            addr_try(0, PRI_W, 1'b0);
            begin
                k = 0;
                while (o_scl_oe_n[0] !== 1'b0 && k < 3000) begin
                    @(negedge i_clk);
                    k++;
                end
                repeat (200) @(negedge i_clk);
                `CHK(bus_scl[0], 1'b0)
                ready = 2'h3;
            end
        join
        `CHK(ctl0.stall_err + ctl1.stall_err, 0)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        t_strap();
        t_boot();
        t_write();
        t_read();
        t_miss();
        t_mask();
        t_stretch();
        results();
    end

    // whole run needs roughly 9k cycles; limit at 30k
    initial begin
        #300_000;
        n_fail++;
        results();
    end
endmodule  // tb_top
